// *** hdl/dmct_params.svh ***
// Offsets, field positions, reset values and timing counts of the compare timer.
`ifndef DMCT_PARAMS_SVH
`define DMCT_PARAMS_SVH

// Device register indexes on the 8-bit peripheral bus.
`define DMCT_A_CTRL      4'h0
`define DMCT_A_STAT      4'h1
`define DMCT_A_CNT_HI    4'h2
`define DMCT_A_CNT_LO    4'h3
`define DMCT_A_CMP_HI    4'h4
`define DMCT_A_CMP_LO    4'h5
`define DMCT_A_IRQ_EN    4'h6
`define DMCT_A_IRQ_REQ   4'h7
`define DMCT_A_EDGE      4'h8

// Reset values and the value read from unmapped offsets.
`define DMCT_CMP_RST     8'hff
`define DMCT_CTRL_RST    8'h00
`define DMCT_STAT_RST    8'h00
`define DMCT_UNREAD      8'hff

// Control register fields.
`define DMCT_B_HI_LVL    7
`define DMCT_B_MODE8     6
`define DMCT_B_LO_LVL    3

// Status register fields.
`define DMCT_B_HI_OVIE   5
`define DMCT_B_HI_CLR    4
`define DMCT_B_LO_OVIE   1
`define DMCT_B_LO_CLR    0
`define DMCT_FLAG_MASK   8'hcc

// Edge select register fields.
`define DMCT_B_EDGE_RISE 0
`define DMCT_B_PIN_FUNC  1

// Clock select codes.
`define DMCT_CK_EXT      3'h0
`define DMCT_CK_DIV32    3'h4
`define DMCT_CK_DIV16    3'h5
`define DMCT_CK_DIV4     3'h6
`define DMCT_CK_WDIV4    3'h7

// Prescaler taps.
`define DMCT_PRE_DIV4    5'h03
`define DMCT_PRE_DIV16   5'h0f
`define DMCT_PRE_DIV32   5'h1f
`define DMCT_WDIV_LAST   2'h3

// Host Wishbone map.
`define DMCT_WB_CMD      8'h00
`define DMCT_WB_STAT     8'h04
`define DMCT_CMD_ADDR_LSB 8
`define DMCT_CMD_WR_BIT  12
`define DMCT_ST_BUSY     8
`define DMCT_ST_HI_IRQ   9
`define DMCT_ST_LO_IRQ   10

`endif

// *** hdl/dmct_pkg.sv ***
// Types of the compare timer link: address and byte shared by both ends, host state type used by the host only.
package dmct_pkg;
	typedef logic [3:0] dmct_addr_t;
	typedef logic [7:0] dmct_byte_t;
	typedef enum logic [1:0] {HS_IDLE, HS_STROBE, HS_CAPTURE} dmct_hstate_t;
endpackage : dmct_pkg

// *** hdl/dmct_bus_if.sv ***
// Peripheral byte bus between the host controller and the compare timer.
`timescale 1ns/10ps
`default_nettype none
interface dmct_bus_if;
	logic                sel;
	logic                we;
	dmct_pkg::dmct_addr_t addr;
	dmct_pkg::dmct_byte_t wdata;
	dmct_pkg::dmct_byte_t rdata;
	logic                hiIrq;
	logic                loIrq;

	modport device (input sel, input we, input addr, input wdata,
		output rdata, output hiIrq, output loIrq);
	modport host (output sel, output we, output addr, output wdata,
		input rdata, input hiIrq, input loIrq);
endinterface : dmct_bus_if
`default_nettype wire

// *** hdl/dmct_prescaler.sv ***
// Prescaler giving one-cycle count enables at clock/4, /16, /32 and watch clock/4.
`timescale 1ns/10ps
`default_nettype none
`include "dmct_params.svh"
module dmct_prescaler (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic watchClkPin,
	output logic      tick4,
	output logic      tick16,
	output logic      tick32,
	output logic      tickW4
);
	import dmct_pkg::*;

	logic [4:0] pre_reg;
	logic       wSync1_reg;
	logic       wSync2_reg;
	logic       wPrev_reg;
	logic [1:0] wDiv_reg;
	logic       wRise;

	assign tick4  = (pre_reg[1:0] == 2'(`DMCT_PRE_DIV4));
	assign tick16 = (pre_reg[3:0] == 4'(`DMCT_PRE_DIV16));
	assign tick32 = (pre_reg == `DMCT_PRE_DIV32);
	assign wRise  = wSync2_reg & ~wPrev_reg;
	assign tickW4 = wRise & (wDiv_reg == `DMCT_WDIV_LAST);

	// The watch clock is asynchronous, so only its resynchronised level is edge detected.
	always_ff @(posedge clock) begin
		if (rst) begin
			pre_reg    <= 5'h00;
			wSync1_reg <= 1'b0;
			wSync2_reg <= 1'b0;
			wPrev_reg  <= 1'b0;
			wDiv_reg   <= 2'h0;
		end else begin
			pre_reg    <= pre_reg + 5'h01;
			wSync1_reg <= watchClkPin;
			wSync2_reg <= wSync1_reg;
			wPrev_reg  <= wSync2_reg;
			if (wRise) begin
				wDiv_reg <= wDiv_reg + 2'h1;
			end
		end
	end
endmodule : dmct_prescaler
`default_nettype wire

// *** hdl/dmct_device.sv ***
// Compare timer device: counters, compare match, toggle pins and flag registers.
//
// Notes on behaviour
// - Two compare bytes, readable, writable, reset all ones.
// - Sixteen-bit mode transfers go through hold byte.
// - Sixteen-bit mode compares whole word, sets high flag.
// - Match sets high pending; enable gates request.
// - Sixteen-bit match toggles high pin, level presettable.
// - Eight-bit mode compares each half independently.
// - Eight-bit mode: each half toggles its pin.
// - Control register write-only, selects modes, resets zero.
// - Bit 7 sets high pin level immediately.
// - Bit 3 sets low pin level immediately.
// - Upper clock select: cascade or four clocks.
// - Lower clock select: event pin or four clocks.
// - Event counting edge chosen by edge select bit.
// - Pin function change while low may count.
// - Status resets zero; flags only cleared by zero.
// - Upper overflow flag set by hardware, read-then-clear.
// - Upper match flag set by hardware, read-then-clear.
// - Upper clear-on-match bit clears counter on match.
// - Lower overflow flag set by hardware, read-then-clear.
// - Lower match flag set by hardware, read-then-clear.
// - Lower clear-on-match bit clears lower counter.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "dmct_params.svh"
module dmct_device (
	input  wire logic   clock,
	input  wire logic   rst,
	dmct_bus_if.device  bus,
	input  wire logic   eventInPin,
	input  wire logic   watchClkPin,
	output logic        hiTogglePin,
	output logic        loTogglePin
);
	import dmct_pkg::*;

	function automatic logic selTick(input logic [2:0] code, input logic altTick,
			input logic t4, input logic t16, input logic t32, input logic tw);
		case (code)
			`DMCT_CK_EXT:   selTick = altTick;
			`DMCT_CK_DIV32: selTick = t32;
			`DMCT_CK_DIV16: selTick = t16;
			`DMCT_CK_DIV4:  selTick = t4;
			`DMCT_CK_WDIV4: selTick = tw;
			default:        selTick = 1'b0;
		endcase
	endfunction : selTick

	dmct_byte_t ctrl_reg;
	dmct_byte_t stat_reg;
	dmct_byte_t armed_reg;
	dmct_byte_t cntHi_reg;
	dmct_byte_t cntLo_reg;
	dmct_byte_t cmpHi_reg;
	dmct_byte_t cmpLo_reg;
	dmct_byte_t hold_reg;
	dmct_byte_t rdata_reg;
	dmct_byte_t rdata_next;
	logic [1:0] irqEn_reg;
	logic [1:0] irqPend_reg;
	logic [1:0] edge_reg;
	logic       evSync1_reg;
	logic       evSync2_reg;
	logic       evPrev_reg;
	logic       eqHiPrev_reg;
	logic       eqLoPrev_reg;
	logic       hiPin_reg;
	logic       loPin_reg;
	logic       tick4;
	logic       tick16;
	logic       tick32;
	logic       tickW4;

	dmct_prescaler u_pre (
		.clock       (clock),
		.rst         (rst),
		.watchClkPin (watchClkPin),
		.tick4       (tick4),
		.tick16      (tick16),
		.tick32      (tick32),
		.tickW4      (tickW4)
	);

	wire wr      = bus.sel & bus.we;
	wire rd      = bus.sel & ~bus.we;
	wire wCtrl   = wr & (bus.addr == `DMCT_A_CTRL);
	wire wStat   = wr & (bus.addr == `DMCT_A_STAT);
	wire wCntHi  = wr & (bus.addr == `DMCT_A_CNT_HI);
	wire wCntLo  = wr & (bus.addr == `DMCT_A_CNT_LO);
	wire wCmpHi  = wr & (bus.addr == `DMCT_A_CMP_HI);
	wire wCmpLo  = wr & (bus.addr == `DMCT_A_CMP_LO);
	wire wIrqEn  = wr & (bus.addr == `DMCT_A_IRQ_EN);
	wire wIrqReq = wr & (bus.addr == `DMCT_A_IRQ_REQ);
	wire wEdge   = wr & (bus.addr == `DMCT_A_EDGE);
	wire rStat   = rd & (bus.addr == `DMCT_A_STAT);
	wire rCntHi  = rd & (bus.addr == `DMCT_A_CNT_HI);
	wire mode8   = ctrl_reg[`DMCT_B_MODE8];

	// With the pin given to another function the counter sees a high level, so switching
	// the function while the pin is low produces an edge that may be counted.
	wire evLevel = edge_reg[`DMCT_B_PIN_FUNC] ? evSync2_reg : 1'b1;
	wire evEdge  = edge_reg[`DMCT_B_EDGE_RISE] ? (evLevel & ~evPrev_reg)
		: (~evLevel & evPrev_reg);

	wire loTick  = selTick(ctrl_reg[2:0], evEdge, tick4, tick16, tick32, tickW4);
	wire loOvf   = loTick & (cntLo_reg == 8'hff);
	wire hiTick  = selTick(ctrl_reg[6:4], loOvf, tick4, tick16, tick32, tickW4);
	wire hiOvf   = hiTick & (cntHi_reg == 8'hff);
	wire loOvfEv = loOvf & mode8;

	wire eqHi    = mode8 ? (cntHi_reg == cmpHi_reg)
		: ({cntHi_reg, cntLo_reg} == {cmpHi_reg, cmpLo_reg});
	wire eqLo    = mode8 & (cntLo_reg == cmpLo_reg);
	// A match is the first cycle of equality, so a stalled counter toggles a pin only once.
	wire matchHi = eqHi & ~eqHiPrev_reg;
	wire matchLo = eqLo & ~eqLoPrev_reg;

	wire clrHi   = matchHi & stat_reg[`DMCT_B_HI_CLR];
	wire clrLo   = mode8 ? (matchLo & stat_reg[`DMCT_B_LO_CLR]) : clrHi;

	wire [7:0] setMask = {hiOvf, matchHi, 2'h0, loOvfEv, matchLo, 2'h0};
	wire [7:0] clrMask = wStat ? (~bus.wdata & armed_reg & `DMCT_FLAG_MASK) : 8'h00;
	wire [7:0] statBase = wStat
		? ((stat_reg & ~clrMask & `DMCT_FLAG_MASK) | (bus.wdata & ~`DMCT_FLAG_MASK))
		: stat_reg;
	wire [7:0] statNext = statBase | setMask;
	wire [7:0] armedNext = (rStat ? (armed_reg | (stat_reg & `DMCT_FLAG_MASK)) : armed_reg)
		& ~clrMask;

	wire [1:0] pendSet = {matchHi | (hiOvf & stat_reg[`DMCT_B_HI_OVIE]),
		matchLo | (loOvfEv & stat_reg[`DMCT_B_LO_OVIE])};
	wire [1:0] pendNext = (wIrqReq ? (irqPend_reg & bus.wdata[1:0]) : irqPend_reg) | pendSet;

	wire [7:0] cntLoNext = wCntLo ? bus.wdata : (clrLo ? 8'h00
		: (loTick ? cntLo_reg + 8'h01 : cntLo_reg));
	wire [7:0] cntHiNext = (wCntLo & ~mode8) ? hold_reg : ((wCntHi & mode8) ? bus.wdata
		: (clrHi ? 8'h00 : (hiTick ? cntHi_reg + 8'h01 : cntHi_reg)));
	wire [7:0] cmpHiNext = (wCmpLo & ~mode8) ? hold_reg
		: ((wCmpHi & mode8) ? bus.wdata : cmpHi_reg);
	wire [7:0] holdNext = (~mode8 & (wCntHi | wCmpHi)) ? bus.wdata
		: ((~mode8 & rCntHi) ? cntLo_reg : hold_reg);

	// Software level writes win over a match in the same cycle.
	wire hiPinNext = wCtrl ? bus.wdata[`DMCT_B_HI_LVL]
		: (matchHi ? ~hiPin_reg : hiPin_reg);
	wire loPinNext = wCtrl ? bus.wdata[`DMCT_B_LO_LVL]
		: (matchLo ? ~loPin_reg : loPin_reg);

	always_comb begin
		case (bus.addr)
			`DMCT_A_STAT:    rdata_next = stat_reg;
			`DMCT_A_CNT_HI:  rdata_next = cntHi_reg;
			`DMCT_A_CNT_LO:  rdata_next = mode8 ? cntLo_reg : hold_reg;
			`DMCT_A_CMP_HI:  rdata_next = cmpHi_reg;
			`DMCT_A_CMP_LO:  rdata_next = cmpLo_reg;
			`DMCT_A_IRQ_EN:  rdata_next = {6'h00, irqEn_reg};
			`DMCT_A_IRQ_REQ: rdata_next = {6'h00, irqPend_reg};
			`DMCT_A_EDGE:    rdata_next = {6'h00, edge_reg};
			default:         rdata_next = `DMCT_UNREAD;
		endcase
	end

	assign bus.rdata   = rdata_reg;
	assign bus.hiIrq   = irqPend_reg[1] & irqEn_reg[1];
	assign bus.loIrq   = irqPend_reg[0] & irqEn_reg[0];
	assign hiTogglePin = hiPin_reg;
	assign loTogglePin = loPin_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_reg     <= `DMCT_CTRL_RST;
			stat_reg     <= `DMCT_STAT_RST;
			armed_reg    <= 8'h00;
			cntHi_reg    <= 8'h00;
			cntLo_reg    <= 8'h00;
			cmpHi_reg    <= `DMCT_CMP_RST;
			cmpLo_reg    <= `DMCT_CMP_RST;
			hold_reg     <= 8'h00;
			rdata_reg    <= 8'h00;
			irqEn_reg    <= 2'h0;
			irqPend_reg  <= 2'h0;
			edge_reg     <= 2'h0;
			evSync1_reg  <= 1'b1;
			evSync2_reg  <= 1'b1;
			evPrev_reg   <= 1'b1;
			eqHiPrev_reg <= 1'b0;
			eqLoPrev_reg <= 1'b0;
			hiPin_reg    <= 1'b0;
			loPin_reg    <= 1'b0;
		end else begin
			if (wCtrl) begin
				ctrl_reg <= bus.wdata;
			end
			if (wCmpLo) begin
				cmpLo_reg <= bus.wdata;
			end
			if (wIrqEn) begin
				irqEn_reg <= bus.wdata[1:0];
			end
			if (wEdge) begin
				edge_reg <= bus.wdata[1:0];
			end
			if (rd) begin
				rdata_reg <= rdata_next;
			end
			stat_reg     <= statNext;
			armed_reg    <= armedNext;
			cntHi_reg    <= cntHiNext;
			cntLo_reg    <= cntLoNext;
			cmpHi_reg    <= cmpHiNext;
			hold_reg     <= holdNext;
			irqPend_reg  <= pendNext;
			evSync1_reg  <= eventInPin;
			evSync2_reg  <= evSync1_reg;
			evPrev_reg   <= evLevel;
			eqHiPrev_reg <= eqHi;
			eqLoPrev_reg <= eqLo;
			hiPin_reg    <= hiPinNext;
			loPin_reg    <= loPinNext;
		end
	end
endmodule : dmct_device
`default_nettype wire

// *** hdl/dmct_host.sv ***
// Host end: Wishbone slave that turns software commands into peripheral bus accesses.
`timescale 1ns/10ps
`default_nettype none
`include "dmct_params.svh"
module dmct_host (
	input  wire logic        clock,
	input  wire logic        rst,
	dmct_bus_if.host         bus,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o
);
	import dmct_pkg::*;

	dmct_hstate_t state_reg;
	logic         ack_reg;
	logic [31:0]  dat_reg;
	logic         sel_reg;
	logic         we_reg;
	dmct_addr_t   addr_reg;
	dmct_byte_t   wdata_reg;
	dmct_byte_t   last_reg;

	wire busy   = (state_reg != HS_IDLE);
	wire access = cyc_i & stb_i & ack_reg;
	// A command while busy is acknowledged but dropped; software polls the busy bit first.
	wire launch = access & we_i & (adr_i == `DMCT_WB_CMD) & (sel_i != 4'h0) & ~busy;
	wire [31:0] statWord = {21'h000000, bus.loIrq, bus.hiIrq, busy, last_reg};
	wire [31:0] rdWord = (adr_i == `DMCT_WB_STAT) ? statWord : 32'h00000000;

	assign ack_o     = ack_reg;
	assign dat_o     = dat_reg;
	assign bus.sel   = sel_reg;
	assign bus.we    = we_reg;
	assign bus.addr  = addr_reg;
	assign bus.wdata = wdata_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= HS_IDLE;
			ack_reg   <= 1'b0;
			dat_reg   <= 32'h00000000;
			sel_reg   <= 1'b0;
			we_reg    <= 1'b0;
			addr_reg  <= 4'h0;
			wdata_reg <= 8'h00;
			last_reg  <= 8'h00;
		end else begin
			ack_reg <= cyc_i & stb_i & ~ack_reg;
			if (cyc_i & stb_i & ~ack_reg & ~we_i) begin
				dat_reg <= rdWord;
			end
			case (state_reg)
				HS_IDLE: begin
					if (launch) begin
						sel_reg   <= 1'b1;
						we_reg    <= dat_i[`DMCT_CMD_WR_BIT];
						addr_reg  <= dat_i[`DMCT_CMD_ADDR_LSB +: 4];
						wdata_reg <= dat_i[7:0];
						state_reg <= HS_STROBE;
					end
				end
				HS_STROBE: begin
					sel_reg   <= 1'b0;
					state_reg <= HS_CAPTURE;
				end
				HS_CAPTURE: begin
					if (~we_reg) begin
						last_reg <= bus.rdata;
					end
					state_reg <= HS_IDLE;
				end
				default: begin
					sel_reg   <= 1'b0;
					state_reg <= HS_IDLE;
				end
			endcase
		end
	end
endmodule : dmct_host
`default_nettype wire

// *** hdl/dmct_dummy_end.sv ***
// Intentionally empty end marker file kept out of compile lists.

// *** tb/dmct_sva.sv ***
// Assertions on the peripheral byte bus and the toggle pins of the compare timer.
`timescale 1ns/10ps
`default_nettype none
module dmct_sva (
	input wire logic                 clock,
	input wire logic                 rst,
	input wire logic                 sel,
	input wire logic                 we,
	input wire dmct_pkg::dmct_addr_t addr,
	input wire dmct_pkg::dmct_byte_t wdata,
	input wire dmct_pkg::dmct_byte_t rdata,
	input wire logic                 hiIrq,
	input wire logic                 loIrq,
	input wire logic                 hiTogglePin,
	input wire logic                 loTogglePin
);
	import dmct_pkg::*;
	// Shadow of the compare bytes; an upper counter byte access spoils the shared hold byte.
	logic       mode8Reg;
	logic       holdOkReg;
	logic       cmpOkReg;
	dmct_byte_t holdReg;
	dmct_byte_t cmpHiReg;
	dmct_byte_t cmpLoReg;
	always_ff @(posedge clock) begin
		if (rst) begin
			mode8Reg <= 1'b0;
			holdOkReg <= 1'b0;
			cmpOkReg <= 1'b1;
			holdReg <= 8'h00;
			cmpHiReg <= 8'hff;
			cmpLoReg <= 8'hff;
		end else if (sel && we) begin
			if (addr == 4'h0)
				mode8Reg <= wdata[6];
			if (addr == 4'h2)
				holdOkReg <= 1'b0;
			if (addr == 4'h4 && mode8Reg)
				cmpHiReg <= wdata;
			if (addr == 4'h4 && !mode8Reg) begin
				holdReg <= wdata;
				holdOkReg <= 1'b1;
			end
			if (addr == 4'h5)
				cmpLoReg <= wdata;
			if (addr == 4'h5 && !mode8Reg) begin
				cmpHiReg <= holdReg;
				cmpOkReg <= holdOkReg;
			end
		end else if (sel && addr == 4'h2) begin
			holdOkReg <= 1'b0;
		end
	end

	AST_RST_PINS: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> !hiTogglePin && !loTogglePin)
		else $error("toggle pins not low after reset");
	AST_RST_IRQ: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> !hiIrq && !loIrq)
		else $error("interrupt request high after reset");
	AST_HI_LEVEL: assert property (@(posedge clock) disable iff (rst)
		sel && we && addr == 4'h0 |=> hiTogglePin == $past(wdata[7]))
		else $error("upper pin does not follow control write");
	AST_LO_LEVEL: assert property (@(posedge clock) disable iff (rst)
		sel && we && addr == 4'h0 |=> loTogglePin == $past(wdata[3]))
		else $error("lower pin does not follow control write");
	AST_CTRL_WO: assert property (@(posedge clock) disable iff (rst)
		sel && !we && addr == 4'h0 |=> rdata == 8'hff)
		else $error("control register read returned its contents");
	AST_IRQ_GATE: assert property (@(posedge clock) disable iff (rst)
		sel && we && addr == 4'h6 && wdata[1:0] == 2'h0 |=> !hiIrq && !loIrq)
		else $error("interrupt request with enables clear");
	AST_CMP_HI_RD: assert property (@(posedge clock) disable iff (rst)
		sel && !we && addr == 4'h4 && cmpOkReg |=> rdata == cmpHiReg)
		else $error("compare upper byte read back wrong");
	AST_CMP_LO_RD: assert property (@(posedge clock) disable iff (rst)
		sel && !we && addr == 4'h5 |=> rdata == cmpLoReg)
		else $error("compare lower byte read back wrong");
	AST_SEL_GAP: assert property (@(posedge clock) disable iff (rst)
		sel |=> !sel [*2])
		else $error("bus accesses closer than three cycles");
endmodule : dmct_sva
`default_nettype wire

// *** tb/test_dual_mode_compare_timer.sv ***
// Self-checking bench: host and device joined, driven over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module test_dual_mode_compare_timer;
	typedef struct {logic w; logic [3:0] i; logic [7:0] d; logic [7:0] e;} dmct_row_t;
	localparam int NR = 14;
	logic        clock;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] datI;
	logic [31:0] datO;
	logic        ack;
	logic        eventInPin;
	logic        hiTogglePin;
	logic        loTogglePin;
	logic [2:0]  watchCnt = 3'h0;
	logic [31:0] q;
	int          errCount = 0;
	int          cmpCount = 0;
	dmct_row_t   rows [NR] = '{'{0, 4, 0, 8'hff}, '{0, 5, 0, 8'hff}, '{0, 1, 0, 8'h00},
		'{0, 0, 0, 8'hff}, '{0, 9, 0, 8'hff}, '{1, 4, 8'h12, 0}, '{0, 4, 0, 8'hff},
		'{1, 5, 8'h34, 0}, '{0, 4, 0, 8'h12}, '{0, 5, 0, 8'h34}, '{1, 1, 8'hff, 0},
		'{0, 1, 0, 8'h33}, '{1, 1, 8'h00, 0}, '{0, 1, 0, 8'h00}};

	dmct_bus_if u_dmct_bus_if ();
	dmct_host u_dmct_host (.clock(clock), .rst(rst), .bus(u_dmct_bus_if), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(datI), .dat_o(datO),
		.ack_o(ack));
	dmct_device u_dmct_device (.clock(clock), .rst(rst), .bus(u_dmct_bus_if),
		.eventInPin(eventInPin), .watchClkPin(watchCnt[2]), .hiTogglePin(hiTogglePin),
		.loTogglePin(loTogglePin));
	dmct_sva u_dmct_sva (.clock(clock), .rst(rst), .sel(u_dmct_bus_if.sel),
		.we(u_dmct_bus_if.we), .addr(u_dmct_bus_if.addr), .wdata(u_dmct_bus_if.wdata),
		.rdata(u_dmct_bus_if.rdata), .hiIrq(u_dmct_bus_if.hiIrq),
		.loIrq(u_dmct_bus_if.loIrq), .hiTogglePin(hiTogglePin), .loTogglePin(loTogglePin));

	always #20 clock = ~clock;

	// A slow watch clock at one eighth of the system clock, so its divide-by-4 ticks every 32.
	always @(posedge clock) watchCnt <= watchCnt + 3'h1;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= d;
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		r = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wbCycle

	// Polls busy both before and after the command, so stale read data is never taken.
	task automatic devAcc(input logic w, input logic [3:0] i, input logic [7:0] d,
		output logic [31:0] r);
		r = 32'h100;
		while (r[8] !== 1'b0)
			wbCycle(1'b0, 8'h04, 32'h0, r);
		wbCycle(1'b1, 8'h00, {19'h0, w, i, d}, r);
		wbCycle(1'b0, 8'h04, 32'h0, r);
		while (r[8] !== 1'b0)
			wbCycle(1'b0, 8'h04, 32'h0, r);
	endtask : devAcc

	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clock);
			eventInPin <= 1'b0;
			repeat (6) @(posedge clock);
			eventInPin <= 1'b1;
			repeat (6) @(posedge clock);
		end
	endtask : pulse

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge clock);
		errCount++;
		$display("Watchdog expired");
		results();
	end

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		datI = 32'h0;
		eventInPin = 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (int k = 0; k < NR; k++) begin
			devAcc(rows[k].w, rows[k].i, rows[k].d, q);
			if (!rows[k].w)
				check($sformatf("row%0d", k), q[7:0], rows[k].e);
		end
		wbCycle(1'b0, 8'h08, 32'h0, q);
		check("unmapped", q, 32'h0);
		$display("Register rows done");
		devAcc(1'b1, 4'h0, 8'h88, q);
		check("hiLevel", hiTogglePin, 1);
		check("loLevel", loTogglePin, 1);
		devAcc(1'b1, 4'h0, 8'h00, q);
		check("hiLow", hiTogglePin, 0);
		check("loLow", loTogglePin, 0);
		$display("Level test done");
		// Pin function is enabled while the pin is high, so no stray count occurs.
		devAcc(1'b1, 4'h4, 8'h00, q);
		devAcc(1'b1, 4'h5, 8'h02, q);
		devAcc(1'b1, 4'h8, 8'h03, q);
		devAcc(1'b1, 4'h1, 8'h10, q);
		devAcc(1'b1, 4'h6, 8'h02, q);
		pulse(2);
		check("hiToggle", hiTogglePin, 1);
		devAcc(1'b0, 4'h1, 8'h00, q);
		check("stat16", q[7:0], 8'h50);
		check("hiIrq", q[9], 1);
		devAcc(1'b0, 4'h2, 8'h00, q);
		check("cntHi", q[7:0], 8'h00);
		devAcc(1'b0, 4'h3, 8'h00, q);
		check("cntLo", q[7:0], 8'h00);
		devAcc(1'b1, 4'h6, 8'h00, q);
		devAcc(1'b0, 4'h7, 8'h00, q);
		check("pending", q[7:0], 8'h02);
		check("hiIrqOff", q[9], 0);
		devAcc(1'b1, 4'h7, 8'h00, q);
		$display("Word match test done");
		devAcc(1'b1, 4'h4, 8'hff, q);
		devAcc(1'b1, 4'h5, 8'h03, q);
		devAcc(1'b1, 4'h0, 8'h40, q);
		devAcc(1'b1, 4'h1, 8'h01, q);
		devAcc(1'b1, 4'h6, 8'h01, q);
		pulse(2);
		check("loEarly", loTogglePin, 0);
		pulse(1);
		check("loToggle", loTogglePin, 1);
		devAcc(1'b0, 4'h1, 8'h00, q);
		check("stat8", q[7:0], 8'h05);
		check("loIrq", q[10], 1);
		pulse(3);
		check("loAgain", loTogglePin, 0);
		devAcc(1'b0, 4'h3, 8'h00, q);
		check("loClear", q[7:0], 8'h00);
		devAcc(1'b1, 4'h8, 8'h02, q);
		@(posedge clock);
		eventInPin <= 1'b0;
		devAcc(1'b0, 4'h3, 8'h00, q);
		check("fallCount", q[7:0], 8'h01);
		eventInPin <= 1'b1;
		devAcc(1'b0, 4'h3, 8'h00, q);
		check("riseIgnored", q[7:0], 8'h01);
		$display("Byte match test done");
		// The lower half runs on clock/4 from f0, so it overflows and then matches 03.
		devAcc(1'b1, 4'h1, 8'h02, q);
		devAcc(1'b1, 4'h3, 8'hf0, q);
		devAcc(1'b1, 4'h0, 8'h46, q);
		repeat (100) @(posedge clock);
		devAcc(1'b0, 4'h1, 8'h00, q);
		check("loOvf", q[7:0], 8'h0e);
		check("loDiv4Toggle", loTogglePin, 1);
		// The upper half counts on the watch clock from just below its compare value.
		devAcc(1'b1, 4'h0, 8'h70, q);
		devAcc(1'b1, 4'h2, 8'hfe, q);
		repeat (100) @(posedge clock);
		devAcc(1'b0, 4'h1, 8'h00, q);
		check("hiOvf", q[7:0], 8'hce);
		check("hiWatchToggle", hiTogglePin, 1);
		check("hiIrqGated", q[9], 0);
		$display("Overflow test done");
		devAcc(1'b1, 4'h0, 8'h88, q);
		rst <= 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check("rstPin", hiTogglePin, 0);
		devAcc(1'b0, 4'h5, 8'h00, q);
		check("rstCmp", q[7:0], 8'hff);
		devAcc(1'b0, 4'h1, 8'h00, q);
		check("rstStat", q[7:0], 8'h00);
		$display("Reset test done");
		results();
	end
endmodule : test_dual_mode_compare_timer
`default_nettype wire
